// file: verilog/i2cm_map.svh
// constants of the serial memory slave: field positions, counts, reset values
`ifndef I2CM_MAP_SVH
`define I2CM_MAP_SVH

// ----------------------------------------------------------------------------
// slave address byte fields
// ----------------------------------------------------------------------------
`define I2CM_SA_CODE_MSB 7
`define I2CM_SA_CODE_LSB 4
`define I2CM_SA_SEL_MSB  3
`define I2CM_SA_SEL_LSB  1
`define I2CM_SA_RW       0

// ----------------------------------------------------------------------------
// bit counter values within one byte frame
// ----------------------------------------------------------------------------
`define I2CM_CNT_ZERO 4'h0
`define I2CM_CNT_LAST 4'h7
`define I2CM_CNT_ACK  4'h8
`define I2CM_CNT_END  4'h9

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define I2CM_ADDR_RST 15'h0000
`define I2CM_BUS_RST  2'h3
`define I2CM_CFG_RST  4'h0

`endif

// file: verilog/i2cm_pkg.sv
// types shared by the serial memory slave
`default_nettype none

package i2cm_pkg;

  // protocol phase of the slave
  typedef enum logic [2:0] {
    st_idle,
    st_dev,
    st_ahi,
    st_alo,
    st_wdat,
    st_rdat
  } i2cm_state_e;

  // decoded events of the two-wire bus
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } i2cm_evt_s;

endpackage

`default_nettype wire

// file: verilog/i2cm_sync.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none

module i2cm_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // pins and filtered levels
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // shift chain; s1 feeds only s2
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // accept a bit once the second and third stages agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout <= RST_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: verilog/i2cm_slave.sv
// two-wire serial slave with 32K x 8 byte memory
`default_nettype none

`include "i2cm_map.svh"

module i2cm_slave
  import i2cm_pkg::*;
#(
  parameter logic [3:0] DEV_CODE = 4'h5, // arbitrary device type code
  parameter int         ADDR_W   = 15,
  parameter int         DEPTH    = 32768
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // serial bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output var  logic       sda_o,
  output var  logic       sda_oe,
  // configuration pins
  input  wire logic [2:0] device_select_pins,
  input  wire logic       write_protect
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic [1:0]        bus_f;
  logic [3:0]        cfg_f;
  logic              scl_f;
  logic              sda_f;
  logic              scl_q;
  logic              sda_q;
  logic              wp_f;
  logic [2:0]        sel_f;
  i2cm_evt_s         ev;
  i2cm_state_e       state;
  logic [3:0]        cnt;
  logic [7:0]        shift;
  logic [7:0]        rx_byte;
  logic              rw;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-9:0] addr_hi;
  logic              byte_done;
  logic              dev_match;
  logic              receiving;
  logic              load_rd;
  logic [7:0]        mem [0:DEPTH-1];

  // --------------------------------------------------------------------------
  // pin synchronisation and edge detection
  // --------------------------------------------------------------------------

  // bus wires, idle high
  i2cm_sync #(
    .WIDTH   (2),
    .RST_VAL (`I2CM_BUS_RST)
  ) u_sync_bus (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({scl_i, sda_i}),
    .dout  (bus_f)
  );

  // static strap pins
  i2cm_sync #(
    .WIDTH   (4),
    .RST_VAL (`I2CM_CFG_RST)
  ) u_sync_cfg (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({write_protect, device_select_pins}),
    .dout  (cfg_f)
  );

  assign scl_f = bus_f[1];
  assign sda_f = bus_f[0];
  assign wp_f  = cfg_f[3];
  assign sel_f = cfg_f[2:0];

  // previous filtered levels
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // bus conditions from filtered levels
  always_comb begin
    ev.start = scl_q && scl_f && sda_q && !sda_f;
    ev.stop  = scl_q && scl_f && !sda_q && sda_f;
    ev.rise  = !scl_q && scl_f;
    ev.fall  = scl_q && !scl_f;
  end

  // --------------------------------------------------------------------------
  // byte decode helpers
  // --------------------------------------------------------------------------
  assign rx_byte   = {shift[6:0], sda_f}; // msb first
  assign byte_done = ev.rise && (cnt == `I2CM_CNT_LAST) && (state != st_idle);
  assign dev_match = (rx_byte[`I2CM_SA_CODE_MSB:`I2CM_SA_CODE_LSB] == DEV_CODE) &&
                     (rx_byte[`I2CM_SA_SEL_MSB:`I2CM_SA_SEL_LSB] == sel_f);
  assign receiving = (state == st_dev) || (state == st_ahi) ||
                     (state == st_alo) || (state == st_wdat);
  // end of ack clock that leads into a data byte to send
  assign load_rd   = ev.fall && (cnt == `I2CM_CNT_END) &&
                     ((state == st_rdat) || ((state == st_dev) && rw));

  // --------------------------------------------------------------------------
  // protocol sequencing
  // --------------------------------------------------------------------------

  // phase and bit counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= st_idle;
      cnt   <= `I2CM_CNT_ZERO;
    end else if (ev.start) begin
      state <= st_dev;
      cnt   <= `I2CM_CNT_ZERO;
    end else if (ev.stop) begin
      state <= st_idle;
      cnt   <= `I2CM_CNT_ZERO;
    end else if (ev.rise && state != st_idle) begin
      if (cnt == `I2CM_CNT_ACK) begin
        cnt <= `I2CM_CNT_END;
        if (state == st_rdat && sda_f) begin
          state <= st_idle;
        end
      end else if (cnt < `I2CM_CNT_ACK) begin
        cnt <= cnt + 4'h1;
      end
      if (byte_done && state == st_dev && !dev_match) begin
        state <= st_idle;
      end
      if (byte_done && state == st_wdat && wp_f) begin
        state <= st_idle;
      end
    end else if (ev.fall && cnt == `I2CM_CNT_END) begin
      cnt <= `I2CM_CNT_ZERO;
      unique case (state)
        st_dev:  state <= rw ? st_rdat : st_ahi;
        st_ahi:  state <= st_alo;
        st_alo:  state <= st_wdat;
        st_wdat: state <= st_wdat;
        st_rdat: state <= st_rdat;
        st_idle: state <= st_idle;
      endcase
    end
  end

  // direction bit of the slave address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rw <= 1'b0;
    end else if (byte_done && state == st_dev) begin
      rw <= rx_byte[`I2CM_SA_RW];
    end
  end

  // shift register: receive on rise, transmit after fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift <= 8'h00;
    end else if (ev.start || ev.stop) begin
      shift <= 8'h00;
    end else if (ev.rise && receiving && cnt < `I2CM_CNT_ACK) begin
      shift <= rx_byte;
    end else if (load_rd) begin
      shift <= mem[addr];
    end else if (ev.fall && state == st_rdat && cnt != `I2CM_CNT_ZERO &&
                 cnt < `I2CM_CNT_ACK) begin
      shift <= {shift[6:0], 1'b0};
    end
  end

  // --------------------------------------------------------------------------
  // address latch and memory
  // --------------------------------------------------------------------------

  // upper address byte, top bit dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_hi <= '0;
    end else if (byte_done && state == st_ahi) begin
      addr_hi <= rx_byte[ADDR_W-9:0];
    end
  end

  // current address, incremented before each read or unprotected write data byte ack, wraps by width
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr <= `I2CM_ADDR_RST;
    end else if (byte_done && state == st_alo) begin
      addr <= {addr_hi, rx_byte};
    end else if (byte_done && state == st_wdat && !wp_f) begin
      addr <= addr + ADDR_W'(1'h1);
    end else if (byte_done && state == st_rdat) begin
      addr <= addr + ADDR_W'(1'h1);
    end
  end

  // array write on the eighth data bit, no page buffer
  always_ff @(posedge clk) begin
    if (byte_done && state == st_wdat && !wp_f) begin
      mem[addr] <= rx_byte;
    end
  end

  // --------------------------------------------------------------------------
  // open-drain data output
  // --------------------------------------------------------------------------
  assign sda_o = 1'b0; // only ever pulls low

  // enable is set only after a falling clock; start, stop and idle also clear it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_oe <= 1'b0;
    end else if (ev.start || ev.stop) begin
      sda_oe <= 1'b0;
    end else if (ev.fall) begin
      if (receiving && cnt == `I2CM_CNT_ACK) begin
        sda_oe <= 1'b1;
      end else if (load_rd) begin
        sda_oe <= !mem[addr][7];
      end else if (state == st_rdat && cnt != `I2CM_CNT_ZERO &&
                   cnt < `I2CM_CNT_ACK) begin
        sda_oe <= !shift[6];
      end else begin
        sda_oe <= 1'b0;
      end
    end else if (state == st_idle) begin
      sda_oe <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  a_start_ready: assert property (@(posedge clk) disable iff (!rst_n)
    ev.start |=> state == st_dev && cnt == `I2CM_CNT_ZERO && !sda_oe)
    else $error("start did not ready the slave");

  a_stop_abort: assert property (@(posedge clk) disable iff (!rst_n)
    ev.stop |=> state == st_idle && !sda_oe)
    else $error("stop did not abort the operation");

  a_oe_after_fall: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(sda_oe) && state != st_idle && !$past(ev.start) && !$past(ev.stop)
      |-> $past(ev.fall))
    else $error("sda enable changed without a falling clock");

  a_dev_mismatch: assert property (@(posedge clk) disable iff (!rst_n)
    byte_done && state == st_dev && !dev_match |=> state == st_idle ##1 !sda_oe)
    else $error("unmatched slave address not ignored");

  a_write_incr: assert property (@(posedge clk) disable iff (!rst_n)
    byte_done && state == st_wdat && !wp_f |=> addr == $past(addr) + ADDR_W'(1'h1))
    else $error("address not incremented after write byte");

  a_wp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    byte_done && state == st_wdat && wp_f |=> addr == $past(addr) && state == st_idle)
    else $error("protected write changed address or state");

  a_write_ack: assert property (@(posedge clk) disable iff (!rst_n)
    ev.fall && state == st_wdat && cnt == `I2CM_CNT_ACK |=> sda_oe)
    else $error("written byte not acknowledged");

  a_read_nak: assert property (@(posedge clk) disable iff (!rst_n)
    ev.rise && state == st_rdat && cnt == `I2CM_CNT_ACK && sda_f
      |=> state == st_idle ##1 !sda_oe)
    else $error("read not ended on no-acknowledge");

  a_read_release: assert property (@(posedge clk) disable iff (!rst_n)
    ev.fall && state == st_rdat && cnt == `I2CM_CNT_ACK |=> !sda_oe)
    else $error("sda not released for master acknowledge");

  a_addr_load: assert property (@(posedge clk) disable iff (!rst_n)
    byte_done && state == st_alo |=> addr == {$past(addr_hi), $past(rx_byte)})
    else $error("address latch not loaded from two bytes");

endmodule

`default_nettype wire

// file: dv/i2cm_mst_model.sv
// two-wire bus master model that drives the serial memory slave
`default_nettype none

module i2cm_mst_model (
  // system clock used for bus timing
  input  wire logic clk,
  // bus lines
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------------
  // bus timing: one bus clock is 16 system clocks (64 ns)
  // ---------------------------------------------------------------------------
  // idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // wait whole system clocks, moving only at falling edges
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one bus clock: data set mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    hold(4);
    scl = 1'b1;
    hold(4);
    r = sda;
    hold(4);
    scl = 1'b0;
    hold(4);
  endtask

  // start or repeated start: data falls while clock high
  task automatic start();
    sda_pull = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_pull = 1'b1;
    hold(8);
    scl = 1'b0;
    hold(4);
  endtask

  // stop: data rises while clock high, bus left idle
  task automatic stop();
    sda_pull = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_pull = 1'b0;
    hold(8);
  endtask

  // send n bits msb first; a whole byte also clocks the acknowledge slot
  task automatic send(input logic [7:0] d, input int n, output logic ack);
    logic r;
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--) bit_io(d[i], r);
    if (n == 8) begin
      bit_io(1'b1, r);
      ack = ~r;
    end
  endtask

  // receive a byte, then acknowledge or withhold it
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench of the serial memory slave
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------------
  // signals and bookkeeping
  // ---------------------------------------------------------------------------
  localparam logic [3:0] DEV = 4'h5; // arbitrary type code
  logic       clk;
  logic       rst_n;
  logic       scl;
  logic       sda_pull;
  logic       sda_o;
  logic       sda_oe;
  logic       wp;
  logic [2:0] sel;
  logic       a;
  logic [7:0] d;
  wire        sda;
  int         failures;
  int         n_tests;

  // wired-and bus with pull-up
  assign sda = ~(sda_pull | sda_oe);

  `define CHK(g, e) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("BAD %0t mismatch got %h exp %h", $time, g, e); \
    end \
  end

  i2cm_slave #(.DEV_CODE(DEV)) i_dut (
    .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .device_select_pins(sel), .write_protect(wp)
  );
  i2cm_mst_model i_mst (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  // ---------------------------------------------------------------------------
  // bus helpers
  // ---------------------------------------------------------------------------
  // start, write slave address and two memory address bytes
  task automatic set_addr(input logic [14:0] ad, input logic top);
    i_mst.start();
    i_mst.send({DEV, sel, 1'b0}, 8, a);
    `CHK(a, 1'b1)
    i_mst.send({top, ad[14:8]}, 8, a);
    `CHK(a, 1'b1)
    i_mst.send(ad[7:0], 8, a);
    `CHK(a, 1'b1)
  endtask

  task automatic wr(input logic [7:0] v, input logic exp_ack);
    i_mst.send(v, 8, a);
    `CHK(a, exp_ack)
  endtask

  task automatic rd_start();
    i_mst.start();
    i_mst.send({DEV, sel, 1'b1}, 8, a);
    `CHK(a, 1'b1)
  endtask

  task automatic rd(input logic [7:0] exp, input logic ack);
    i_mst.recv(ack, d);
    `CHK(d, exp)
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  // every select value, wrong select bit and wrong type code
  task automatic sc_select();
    for (int s = 0; s < 8; s++) begin
      sel = s[2:0];
      i_mst.start();
      i_mst.send({DEV, sel, 1'b0}, 8, a);
      `CHK(a, 1'b1)
      i_mst.start();
      i_mst.send({DEV, sel ^ 3'h1, 1'b0}, 8, a);
      `CHK(a, 1'b0)
      i_mst.start();
      i_mst.send({DEV ^ 4'h8, sel, 1'b1}, 8, a);
      `CHK(a, 1'b0)
      i_mst.stop();
    end
  endtask

  // write across the top, then selective, wrapped and current reads
  task automatic sc_wrap();
    set_addr(15'h7fff, 1'b1);
    wr(8'ha5, 1'b1);
    wr(8'h3c, 1'b1);
    wr(8'h96, 1'b1);
    i_mst.stop();
    set_addr(15'h7fff, 1'b0);
    rd_start();
    rd(8'ha5, 1'b1);
    rd(8'h3c, 1'b0);
    rd_start();
    rd(8'h96, 1'b0);
    // let the fall that ends the nak clock reach the slave before looking
    i_mst.hold(4);
    `CHK(sda_oe, 1'b0)
    `CHK(sda, 1'b1)
    i_mst.stop();
    `CHK(sda_o, 1'b0)
  endtask

  // protected write: no ack, no change, no increment
  task automatic sc_protect();
    set_addr(15'h0005, 1'b0);
    wr(8'h77, 1'b1);
    i_mst.stop();
    wp = 1'b1;
    set_addr(15'h0005, 1'b0);
    wr(8'h11, 1'b0);
    i_mst.stop();
    wp = 1'b0;
    rd_start();
    rd(8'h77, 1'b0);
    i_mst.stop();
  endtask

  // a byte cut short by stop leaves memory untouched
  task automatic sc_abort();
    set_addr(15'h0008, 1'b0);
    wr(8'h42, 1'b1);
    wr(8'h24, 1'b1);
    i_mst.stop();
    set_addr(15'h0009, 1'b0);
    i_mst.send(8'hff, 4, a);
    i_mst.stop();
    set_addr(15'h0008, 1'b0);
    rd_start();
    rd(8'h42, 1'b1);
    rd(8'h24, 1'b0);
    i_mst.stop();
  endtask

  // ---------------------------------------------------------------------------
  // clock, sequence, watchdog and verdict
  // ---------------------------------------------------------------------------
  task automatic test_done();
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    wp = 1'b0;
    sel = 3'h5;
    failures = 0;
    n_tests = 0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    sc_select();
    sc_wrap();
    sc_protect();
    sc_abort();
    test_done();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule

`default_nettype wire
